// ### design/iorsd_map.svh
`ifndef IORSD_MAP_SVH
`define IORSD_MAP_SVH
// io-to-data offset, io-address limits and data-space addresses
`define IORSD_IO_TO_DATA 8'h20
`define IORSD_IO_LAST 8'h3f
`define IORSD_BIT_LAST 8'h1f
`define IORSD_EXT_FIRST 8'h60
`define IORSD_A_PINS 8'h20
`define IORSD_A_DIR 8'h21
`define IORSD_A_LATCH 8'h22
`define IORSD_B_PINS 8'h23
`define IORSD_B_DIR 8'h24
`define IORSD_B_LATCH 8'h25
`define IORSD_C_PINS 8'h26
`define IORSD_C_DIR 8'h27
`define IORSD_C_LATCH 8'h28
`define IORSD_D_PINS 8'h29
`define IORSD_D_DIR 8'h2a
`define IORSD_D_LATCH 8'h2b
`define IORSD_TFLG0 8'h35
`define IORSD_TFLG1 8'h36
`define IORSD_TFLG2 8'h37
`define IORSD_PCFLG 8'h3b
`define IORSD_ADIS 8'h7e
`define IORSD_CDIS 8'h7f
`define IORSD_T1CA 8'h80
`define IORSD_T1CB 8'h81
`define IORSD_T1FC 8'h82
`define IORSD_T1CNTL 8'h84
`define IORSD_T1CNTH 8'h85
`define IORSD_T1CAPL 8'h86
`define IORSD_T1CAPH 8'h87
`define IORSD_T1MAL 8'h88
`define IORSD_T1MAH 8'h89
`define IORSD_T1MBL 8'h8a
`define IORSD_T1MBH 8'h8b
// implemented bits of flag, comparator disable and timer1 control registers
`define IORSD_TFLG0_MASK 8'h07
`define IORSD_TFLG1_MASK 8'h27
`define IORSD_TFLG2_MASK 8'h07
`define IORSD_PCFLG_MASK 8'h0f
`define IORSD_CDIS_MASK 8'h03
`define IORSD_T1CB_MASK 8'hdf
`define IORSD_T1CA_MASK 8'hf3
`define IORSD_T1FC_MASK 8'hc0
`define IORSD_RESET_VAL 8'h00
`endif

// ### design/iorsd_pkg.sv
`default_nettype none
package iorsd_pkg;
	typedef enum logic [2:0]
	{
		IORSD_OP_NONE = 3'b000,
		IORSD_OP_IN = 3'b001,
		IORSD_OP_OUT = 3'b010,
		IORSD_OP_SET_BIT = 3'b011,
		IORSD_OP_CLR_BIT = 3'b100,
		IORSD_OP_SKIP_ONE = 3'b101,
		IORSD_OP_SKIP_ZERO = 3'b110,
		IORSD_OP_DATA_LOAD = 3'b111
	} iorsd_op_t;
	typedef logic [7:0] iorsd_byte_t;
endpackage : iorsd_pkg
`default_nettype wire

// ### design/iorsd_decoder.sv
// Contract
// - bit set and clear act only on io addresses 0x00 to 0x1f
// - skip-if-bit-one and skip-if-bit-zero test one bit in low range
// - some status flags clear on writing one; zero leaves them
// - bit set/clear is read-modify-write; set flags get cleared too
// - in and out instructions reach io addresses 0x00 to 0x3f only
// - data-space access maps each register at io address plus 0x20
// - extended region 0x60 to 0xff reachable only by load and store
`timescale 1ns/1ns
`default_nettype none
`include "iorsd_map.svh"
module iorsd_decoder
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	// core request
	input wire logic req_valid,
	input wire iorsd_pkg::iorsd_op_t req_op,
	input wire logic data_store_instr,
	input wire logic [7:0] req_addr,
	input wire logic [2:0] req_bit,
	input wire logic [7:0] req_wdata,
	// core answer
	output logic [7:0] rsp_rdata,
	output logic rsp_skip,
	output logic rsp_valid,
	output logic rsp_refused,
	// port pins
	input wire logic [7:0] pin_in [4],
	output logic [7:0] port_direction [4],
	output logic [7:0] port_latch [4],
	// peripheral flag events and controls
	input wire logic [7:0] flag_set [4],
	output logic [7:0] flag_state [4],
	output logic [7:0] analog_disable,
	output logic [7:0] comparator_disable,
	output logic [7:0] timer1_regs [11],
	output logic [1:0] timer1_force_pulse
);
	import iorsd_pkg::*;

	// ***********************************************
	// address resolution
	// ***********************************************
	logic [7:0] daddr;
	logic legal;
	logic is_write;
	logic is_bitop;
	logic is_data;
	// io forms wrap past 0xff; legal stops those before any write
	always_comb
	begin
		is_data = (req_op == IORSD_OP_DATA_LOAD) || data_store_instr;
		is_bitop = (req_op == IORSD_OP_SET_BIT) || (req_op == IORSD_OP_CLR_BIT)
			|| (req_op == IORSD_OP_SKIP_ONE) || (req_op == IORSD_OP_SKIP_ZERO);
		is_write = data_store_instr || (req_op == IORSD_OP_OUT)
			|| (req_op == IORSD_OP_SET_BIT) || (req_op == IORSD_OP_CLR_BIT);
		if (is_data)
		begin
			daddr = req_addr;
			legal = 1'b1;
		end
		else if (is_bitop)
		begin
			daddr = req_addr + `IORSD_IO_TO_DATA;
			legal = (req_addr <= `IORSD_BIT_LAST);
		end
		else
		begin
			daddr = req_addr + `IORSD_IO_TO_DATA;
			legal = (req_addr <= `IORSD_IO_LAST);
		end
	end

	// ***********************************************
	// read multiplexer
	// ***********************************************
	// one address selects one byte; unused reads as zero
	logic [7:0] rd_val;
	logic hit;
	always_comb
	begin
		hit = 1'b1;
		unique case (daddr)
			// pin levels read live: inputs are already synchronous
			`IORSD_A_PINS: rd_val = pin_in[0];
			`IORSD_A_DIR: rd_val = port_direction[0];
			`IORSD_A_LATCH: rd_val = port_latch[0];
			`IORSD_B_PINS: rd_val = pin_in[1];
			`IORSD_B_DIR: rd_val = port_direction[1];
			`IORSD_B_LATCH: rd_val = port_latch[1];
			`IORSD_C_PINS: rd_val = pin_in[2];
			`IORSD_C_DIR: rd_val = port_direction[2];
			`IORSD_C_LATCH: rd_val = port_latch[2];
			`IORSD_D_PINS: rd_val = pin_in[3];
			`IORSD_D_DIR: rd_val = port_direction[3];
			`IORSD_D_LATCH: rd_val = port_latch[3];
			`IORSD_TFLG0: rd_val = flag_state[0];
			`IORSD_TFLG1: rd_val = flag_state[1];
			`IORSD_TFLG2: rd_val = flag_state[2];
			`IORSD_PCFLG: rd_val = flag_state[3];
			`IORSD_ADIS: rd_val = analog_disable;
			`IORSD_CDIS: rd_val = comparator_disable;
			`IORSD_T1CA: rd_val = timer1_regs[0];
			`IORSD_T1CB: rd_val = timer1_regs[1];
			`IORSD_T1CNTL: rd_val = timer1_regs[3];
			`IORSD_T1CNTH: rd_val = timer1_regs[4];
			`IORSD_T1CAPL: rd_val = timer1_regs[5];
			`IORSD_T1CAPH: rd_val = timer1_regs[6];
			`IORSD_T1MAL: rd_val = timer1_regs[7];
			`IORSD_T1MAH: rd_val = timer1_regs[8];
			`IORSD_T1MBL: rd_val = timer1_regs[9];
			`IORSD_T1MBH: rd_val = timer1_regs[10];
			default:
			begin
				rd_val = `IORSD_RESET_VAL;
				// write-only force byte is a hit so its strobe fires
				hit = (daddr == `IORSD_T1FC);
			end
		endcase
	end

	// ***********************************************
	// write value and strobes
	// ***********************************************
	// bit ops write back the whole byte read, so set flags clear too
	logic [7:0] wr_val;
	logic [7:0] bit_mask;
	logic wr_en;
	always_comb
	begin
		bit_mask = 8'h01 << req_bit;
		unique case (req_op)
			IORSD_OP_SET_BIT: wr_val = rd_val | bit_mask;
			IORSD_OP_CLR_BIT: wr_val = rd_val & ~bit_mask;
			default: wr_val = req_wdata;
		endcase
		// unused addresses simply absorb the write
		wr_en = clk_en && req_valid && legal && is_write && hit;
	end

	// ***********************************************
	// port registers
	// ***********************************************
	// one slice per port; the three registers sit a byte apart
	logic [7:0] next_dir [4];
	logic [7:0] next_latch [4];
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_port
			always_comb
			begin
				next_dir[g] = port_direction[g];
				next_latch[g] = port_latch[g];
				if (wr_en && daddr == `IORSD_A_DIR + 8'(3 * g))
					next_dir[g] = wr_val;
				if (wr_en && daddr == `IORSD_A_LATCH + 8'(3 * g))
					next_latch[g] = wr_val;
			end
			always_ff @(posedge ref_clk)
			begin
				if (srst)
				begin
					port_direction[g] <= `IORSD_RESET_VAL;
					port_latch[g] <= `IORSD_RESET_VAL;
				end
				else if (clk_en)
				begin
					port_direction[g] <= next_dir[g];
					port_latch[g] <= next_latch[g];
				end
			end
		end
	endgenerate

	// ***********************************************
	// write-one-to-clear flags
	// ***********************************************
	localparam logic [7:0] FLAG_ADDR [4] = '{`IORSD_TFLG0, `IORSD_TFLG1,
		`IORSD_TFLG2, `IORSD_PCFLG};
	localparam logic [7:0] FLAG_MASK [4] = '{`IORSD_TFLG0_MASK,
		`IORSD_TFLG1_MASK, `IORSD_TFLG2_MASK, `IORSD_PCFLG_MASK};
	// unimplemented flag bits never set, so they read zero
	logic [7:0] next_flag [4];
	generate
		for (g = 0; g < 4; g++)
		begin : g_flag
			always_comb
			begin
				next_flag[g] = flag_state[g];
				if (wr_en && daddr == FLAG_ADDR[g])
					next_flag[g] = flag_state[g] & ~wr_val;
				// a new event wins over a same-cycle clear
				next_flag[g] = (next_flag[g] | flag_set[g]) & FLAG_MASK[g];
			end
			always_ff @(posedge ref_clk)
			begin
				if (srst)
					flag_state[g] <= `IORSD_RESET_VAL;
				else if (clk_en)
					flag_state[g] <= next_flag[g];
			end
		end
	endgenerate

	// ***********************************************
	// extended region registers
	// ***********************************************
	localparam logic [7:0] T1_ADDR [11] = '{`IORSD_T1CA, `IORSD_T1CB,
		`IORSD_T1FC, `IORSD_T1CNTL, `IORSD_T1CNTH, `IORSD_T1CAPL,
		`IORSD_T1CAPH, `IORSD_T1MAL, `IORSD_T1MAH, `IORSD_T1MBL,
		`IORSD_T1MBH};
	// force byte self-clears, so its strobe lasts one enabled cycle
	logic [7:0] next_t1 [11];
	generate
		for (g = 0; g < 11; g++)
		begin : g_t1
			always_comb
			begin
				next_t1[g] = timer1_regs[g];
				if (g == 2)
					next_t1[g] = `IORSD_RESET_VAL;
				if (wr_en && daddr == T1_ADDR[g])
					next_t1[g] = wr_val;
				if (g == 0)
					next_t1[g] = next_t1[g] & `IORSD_T1CA_MASK;
				if (g == 1)
					next_t1[g] = next_t1[g] & `IORSD_T1CB_MASK;
				if (g == 2)
					next_t1[g] = next_t1[g] & `IORSD_T1FC_MASK;
			end
			always_ff @(posedge ref_clk)
			begin
				if (srst)
					timer1_regs[g] <= `IORSD_RESET_VAL;
				else if (clk_en)
					timer1_regs[g] <= next_t1[g];
			end
		end
	endgenerate

	// ***********************************************
	// disables, force strobe, answer
	// ***********************************************
	// disable bytes have no side effects: plain stored values
	logic [7:0] next_adis;
	logic [7:0] next_cdis;
	logic [1:0] next_force;
	logic [7:0] next_rdata;
	logic next_skip;
	logic next_valid;
	logic next_refused;
	always_comb
	begin
		next_adis = analog_disable;
		next_cdis = comparator_disable;
		if (wr_en && daddr == `IORSD_ADIS)
			next_adis = wr_val;
		if (wr_en && daddr == `IORSD_CDIS)
			next_cdis = wr_val & `IORSD_CDIS_MASK;
		// force bits are write-only: a one-cycle pulse, read back as zero
		next_force = next_t1[2][7:6];
		next_valid = req_valid;
		next_refused = req_valid && !legal;
		// refused reads give zero so stale data cannot leak
		next_rdata = legal ? rd_val : `IORSD_RESET_VAL;
		next_skip = 1'b0;
		if (req_valid && legal && req_op == IORSD_OP_SKIP_ONE)
			next_skip = rd_val[req_bit];
		if (req_valid && legal && req_op == IORSD_OP_SKIP_ZERO)
			next_skip = !rd_val[req_bit];
	end
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			analog_disable <= `IORSD_RESET_VAL;
			comparator_disable <= `IORSD_RESET_VAL;
			timer1_force_pulse <= 2'h0;
			rsp_rdata <= `IORSD_RESET_VAL;
			rsp_skip <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_refused <= 1'b0;
		end
		else if (clk_en)
		begin
			analog_disable <= next_adis;
			comparator_disable <= next_cdis;
			timer1_force_pulse <= next_force;
			rsp_rdata <= next_rdata;
			rsp_skip <= next_skip;
			rsp_valid <= next_valid;
			rsp_refused <= next_refused;
		end
	end
endmodule : iorsd_decoder
`default_nettype wire

// ### testbench/iorsd_core.sv
`timescale 1ns/1ns
`default_nettype none
module iorsd_core
(
	// clock
	input wire logic ref_clk,
	// request
	output logic req_valid,
	output iorsd_pkg::iorsd_op_t req_op,
	output logic data_store_instr,
	output logic [7:0] req_addr,
	output logic [2:0] req_bit,
	output logic [7:0] req_wdata,
	// answer
	input wire logic [7:0] rsp_rdata,
	input wire logic rsp_skip,
	input wire logic rsp_refused
);
	import iorsd_pkg::*;
	logic [7:0] rd;
	logic sk, rf;
	initial
	begin
		req_valid = 1'b0;
		req_op = IORSD_OP_NONE;
		data_store_instr = 1'b0;
		req_addr = 8'h00;
		req_bit = 3'h0;
		req_wdata = 8'h00;
	end
	// request held until the next one, so no gap lands on the taking edge
	task xfer(input iorsd_op_t o, input logic s, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d);
		req_valid = 1'b1;
		req_op = o;
		data_store_instr = s;
		req_addr = a;
		req_bit = b;
		req_wdata = d;
		@(negedge ref_clk);
		rd = rsp_rdata;
		sk = rsp_skip;
		rf = rsp_refused;
	endtask : xfer
endmodule : iorsd_core
`default_nettype wire

// ### testbench/iorsd_decoder_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "iorsd_map.svh"
module iorsd_decoder_chk
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	// request
	input wire logic req_valid,
	input wire iorsd_pkg::iorsd_op_t req_op,
	input wire logic data_store_instr,
	input wire logic [7:0] req_addr,
	input wire logic [2:0] req_bit,
	input wire logic [7:0] req_wdata,
	// answer and state
	input wire logic [7:0] rsp_rdata,
	input wire logic rsp_skip,
	input wire logic rsp_valid,
	input wire logic rsp_refused,
	input wire logic [7:0] port_direction [4],
	input wire logic [7:0] port_latch [4],
	input wire logic [7:0] flag_set [4],
	input wire logic [7:0] flag_state [4],
	input wire logic [7:0] analog_disable
);
	import iorsd_pkg::*;
	logic skip_exp, next_skip_exp, go;
	assign go = req_valid && clk_en;
	always_comb
		next_skip_exp = port_latch[0][req_bit] ~^ (req_op == IORSD_OP_SKIP_ONE);
	always_ff @(posedge ref_clk)
		skip_exp <= next_skip_exp;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	sequence s_io(o, a);
		go && !data_store_instr && req_op == o && req_addr == a;
	endsequence
	sequence s_store(a);
		go && data_store_instr && req_addr == a;
	endsequence
	property p_ans;
		go |=> rsp_valid;
	endproperty
	property p_bit_ref;
		go && (req_op == IORSD_OP_SET_BIT || req_op == IORSD_OP_CLR_BIT)
			&& req_addr > `IORSD_BIT_LAST |=> rsp_refused;
	endproperty
	property p_set;
		s_io(IORSD_OP_SET_BIT, 8'h02) |=>
			port_latch[0] == ($past(port_latch[0]) | (8'h01 << $past(req_bit)));
	endproperty
	property p_skip;
		(s_io(IORSD_OP_SKIP_ONE, 8'h02) or s_io(IORSD_OP_SKIP_ZERO, 8'h02))
			|=> rsp_skip == skip_exp;
	endproperty
	property p_w1c;
		s_io(IORSD_OP_OUT, 8'h15) ##0 flag_set[0] == 8'h00 |=>
			flag_state[0] == ($past(flag_state[0]) & ~$past(req_wdata));
	endproperty
	property p_rmw;
		s_io(IORSD_OP_SET_BIT, 8'h15) ##0 flag_set[0] == 8'h00
			|=> flag_state[0] == 8'h00;
	endproperty
	property p_io_ref;
		go && (req_op == IORSD_OP_IN || req_op == IORSD_OP_OUT)
			&& req_addr > `IORSD_IO_LAST |=> rsp_refused;
	endproperty
	property p_store;
		s_store(`IORSD_ADIS) |=> analog_disable == $past(req_wdata);
	endproperty
	property p_load;
		s_io(IORSD_OP_DATA_LOAD, `IORSD_A_DIR) |=>
			rsp_rdata == $past(port_direction[0]);
	endproperty
	property p_unused;
		s_io(IORSD_OP_DATA_LOAD, 8'h8c) |=> rsp_rdata == 8'h00 && !rsp_refused;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	a_bit_ref: assert property (p_bit_ref) else $error("bit range");
	a_set: assert property (p_set) else $error("bit set wrong");
	a_skip: assert property (p_skip) else $error("skip wrong");
	a_w1c: assert property (p_w1c) else $error("flag clear");
	a_rmw: assert property (p_rmw) else $error("rmw flags");
	a_io_ref: assert property (p_io_ref) else $error("io range");
	a_store: assert property (p_store) else $error("ext store");
	a_load: assert property (p_load) else $error("load map");
	a_unused: assert property (p_unused) else $error("unused read");
endmodule : iorsd_decoder_chk
bind iorsd_decoder iorsd_decoder_chk chk_u (.ref_clk(ref_clk), .srst(srst),
	.clk_en(clk_en), .req_valid(req_valid), .req_op(req_op),
	.data_store_instr(data_store_instr), .req_addr(req_addr),
	.req_bit(req_bit), .req_wdata(req_wdata), .rsp_rdata(rsp_rdata),
	.rsp_skip(rsp_skip), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused),
	.port_direction(port_direction), .port_latch(port_latch),
	.flag_set(flag_set), .flag_state(flag_state),
	.analog_disable(analog_disable));
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "iorsd_map.svh"
module testbench;
	import iorsd_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic rv, dst, sk, rf, vl;
	logic ce = 1'b1;
	iorsd_op_t op;
	logic [7:0] ad, wd, rd, v, b, adis, cdis;
	logic [2:0] bn;
	logic [1:0] fp;
	logic [7:0] pin_in [4], flag_set [4], dir [4], lat [4], flg [4], t1 [11];
	int err_count = 0;
	int n_tests = 0;
	always #5 ref_clk = ~ref_clk;
	iorsd_decoder dut_u (.ref_clk(ref_clk), .srst(srst), .clk_en(ce),
		.req_valid(rv), .req_op(op), .data_store_instr(dst), .req_addr(ad),
		.req_bit(bn), .req_wdata(wd), .rsp_rdata(rd), .rsp_skip(sk),
		.rsp_valid(vl), .rsp_refused(rf), .pin_in(pin_in),
		.port_direction(dir), .port_latch(lat), .flag_set(flag_set),
		.flag_state(flg), .analog_disable(adis), .comparator_disable(cdis),
		.timer1_regs(t1), .timer1_force_pulse(fp));
	iorsd_core core_u (.ref_clk(ref_clk), .req_valid(rv), .req_op(op),
		.data_store_instr(dst), .req_addr(ad), .req_bit(bn), .req_wdata(wd),
		.rsp_rdata(rd), .rsp_skip(sk), .rsp_refused(rf));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task load(input logic [7:0] a, input logic [7:0] e);
		core_u.xfer(IORSD_OP_DATA_LOAD, 1'b0, a, 3'h0, 8'h00);
		chk(core_u.rd, e);
	endtask : load
	task sto(input logic [7:0] a, input logic [7:0] d);
		core_u.xfer(IORSD_OP_NONE, 1'b1, a, 3'h0, d);
	endtask : sto
	// takes the data address, issues the io one
	task io(input iorsd_op_t o, input logic [7:0] a, input logic [2:0] n,
		input logic [7:0] d);
		core_u.xfer(o, 1'b0, a - `IORSD_IO_TO_DATA, n, d);
	endtask : io
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	initial
	begin
		#20000;
		err_count++;
		end_of_test;
	end
	initial
	begin
		foreach (pin_in[i]) pin_in[i] = 8'h00;
		foreach (flag_set[i]) flag_set[i] = 8'h00;
		repeat (10) @(negedge ref_clk);
		srst = 1'b0;
		load(`IORSD_D_LATCH, `IORSD_RESET_VAL);
		load(`IORSD_T1MBH, `IORSD_RESET_VAL);
		for (int i = 0; i < 4; i++)
		begin
			v = 8'(i);
			b = 8'(3 * i);
			pin_in[i] = 8'h3c ^ v;
			sto(`IORSD_A_DIR + b, 8'h50 | v);
			chk(dir[i], 8'h50 | v);
			io(IORSD_OP_OUT, `IORSD_A_LATCH + b, 3'h0, 8'ha0 | v);
			chk(lat[i], 8'ha0 | v);
			io(IORSD_OP_IN, `IORSD_A_DIR + b, 3'h0, 8'h00);
			chk(core_u.rd, 8'h50 | v);
			load(`IORSD_A_DIR + b, 8'h50 | v);
			load(`IORSD_A_LATCH + b, 8'ha0 | v);
			load(`IORSD_A_PINS + b, 8'h3c ^ v);
		end
		io(IORSD_OP_SET_BIT, `IORSD_A_LATCH, 3'd0, 8'h00);
		chk(lat[0], 8'ha1);
		io(IORSD_OP_CLR_BIT, `IORSD_A_LATCH, 3'd7, 8'h00);
		chk(lat[0], 8'h21);
		io(IORSD_OP_SKIP_ONE, `IORSD_A_LATCH, 3'd5, 8'h00);
		chk(8'(core_u.sk), 8'h01);
		io(IORSD_OP_SKIP_ZERO, `IORSD_A_LATCH, 3'd1, 8'h00);
		chk(8'(core_u.sk), 8'h01);
		io(IORSD_OP_SKIP_ONE, `IORSD_A_LATCH, 3'd1, 8'h00);
		chk(8'(core_u.sk), 8'h00);
		core_u.xfer(IORSD_OP_SET_BIT, 1'b0, 8'h20, 3'd0, 8'h00);
		chk(8'(core_u.rf), 8'h01);
		foreach (flag_set[i]) flag_set[i] = 8'hff;
		@(negedge ref_clk);
		foreach (flag_set[i]) flag_set[i] = 8'h00;
		load(`IORSD_TFLG0, `IORSD_TFLG0_MASK);
		load(`IORSD_TFLG1, `IORSD_TFLG1_MASK);
		load(`IORSD_TFLG2, `IORSD_TFLG2_MASK);
		load(`IORSD_PCFLG, `IORSD_PCFLG_MASK);
		sto(`IORSD_PCFLG, 8'h05);
		chk(flg[3], 8'h0a);
		chk(flg[2], `IORSD_TFLG2_MASK);
		io(IORSD_OP_OUT, `IORSD_TFLG0, 3'd0, 8'h01);
		chk(flg[0], 8'h06);
		sto(`IORSD_TFLG0, 8'h00);
		chk(flg[0], 8'h06);
		io(IORSD_OP_SET_BIT, `IORSD_TFLG0, 3'd0, 8'h00);
		chk(flg[0], 8'h00);
		// an event in the clearing cycle must survive
		flag_set[0] = 8'h02;
		io(IORSD_OP_OUT, `IORSD_TFLG0, 3'd0, 8'h02);
		flag_set[0] = 8'h00;
		chk(flg[0], 8'h02);
		// cleared bit writes zero back, so only that flag survives
		io(IORSD_OP_CLR_BIT, `IORSD_TFLG1, 3'd0, 8'h00);
		chk(flg[1], 8'h01);
		core_u.xfer(IORSD_OP_IN, 1'b0, 8'h40, 3'd0, 8'h00);
		chk(8'(core_u.rf), 8'h01);
		core_u.xfer(IORSD_OP_IN, 1'b0, 8'h3f, 3'd0, 8'h00);
		chk(8'(core_u.rf), 8'h00);
		sto(`IORSD_ADIS, 8'h5a);
		chk(adis, 8'h5a);
		io(IORSD_OP_OUT, `IORSD_ADIS, 3'd0, 8'hff);
		chk(adis, 8'h5a);
		io(IORSD_OP_SET_BIT, `IORSD_ADIS, 3'd0, 8'h00);
		chk(adis, 8'h5a);
		// a frozen cycle must not take the store
		ce = 1'b0;
		sto(`IORSD_ADIS, 8'h33);
		ce = 1'b1;
		chk(adis, 8'h5a);
		sto(`IORSD_CDIS, `IORSD_CDIS_MASK);
		chk(cdis, `IORSD_CDIS_MASK);
		load(`IORSD_CDIS, `IORSD_CDIS_MASK);
		sto(`IORSD_T1CNTH, 8'h12);
		chk(t1[4], 8'h12);
		load(`IORSD_T1CNTH, 8'h12);
		// force bits strobe while written, then read back as zero
		sto(`IORSD_T1FC, `IORSD_T1FC_MASK);
		chk(8'(fp), 8'h03);
		load(`IORSD_T1FC, 8'h00);
		chk(8'(fp), 8'h00);
		load(8'h8c, 8'h00);
		chk(8'(core_u.rf), 8'h00);
		chk(8'(vl), 8'h01);
		end_of_test;
	end
endmodule : testbench
`default_nettype wire
